// ---- spb_pkg.sv ----
// constants and types shared by the pass-through exchange buffer block
// Contract
// - enable bit runs and reports pass-through mode
// - password protection guards buffer when enabled
// - 64-byte volatile buffer carries data across
// - buffer sits at top of sector 0
// - same procedure in both transfer directions
// - direction bit in session writable by host only
// - both sides may write default direction config
// - no memory lock while buffer fills
// - enable only from host, both supplies present
// - mode clears when either side loses power
// - fast write fills whole buffer at once
// - unmapped last-sector pages answer NAK
// - buffer appears at pages f0h to ffh
// - terminator page ffh hands over ownership
// - mirror and pass-through never both active
package spb_pkg;
  localparam int BUF_WORDS = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_SESSION = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [1:0] BUF_SEL = 2'h1;
  localparam int SESS_PT = 0;
  localparam int SESS_DIR = 1;
  localparam int SESS_MIRROR = 2;
  localparam int SESS_PROT = 3;
  localparam int SESS_AUTH_EN = 4;
  localparam int CFG_DIR = 0;
  localparam int STAT_OWNER_HOST = 0;
  localparam int STAT_FIELD = 1;
  localparam int STAT_VCC = 2;
  localparam int STAT_FILLING = 3;
  localparam int STAT_PT = 4;
  localparam logic CONFIG_DIR_RST = 1'h0;
  localparam logic DIR_NFC_TO_HOST = 1'h1;
  localparam logic OWNER_HOST = 1'h1;
  localparam logic [3:0] PAGE_BUF_HI = 4'hf;
  localparam logic [3:0] PAGE_TERM = 4'hf;
  localparam logic [3:0] PAGE_FIRST = 4'h0;
  localparam logic [7:0] PAGE_SESS0 = 8'hf8;
  localparam logic [7:0] PAGE_SESS1 = 8'hf9;
  localparam logic [7:0] PAGE_BAD0 = 8'hea;
  localparam logic [7:0] PAGE_BAD1 = 8'heb;
  localparam logic [7:0] PAGE_BAD2 = 8'hee;
  localparam logic [7:0] PAGE_BAD3 = 8'hef;
  localparam logic [1:0] SECT_MAIN = 2'h0;
  localparam logic [1:0] SECT_EXT = 2'h1;
  localparam logic [1:0] SECT_SESS = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DISCARD = 2'b10
  } spb_nfc_st_t;
endpackage

// ---- spb_fifo.sv ----
// small word fifo in front of the exchange buffer
`timescale 1ns/10ps
`default_nettype none
module spb_fifo
  import spb_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output var logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_q[rd_ptr_q];

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge aclk)
    begin
      if (push && wr_ptr_q == AW'(i))
        mem_q[i] <= in_data;
    end
  end

  // flags are registered so that neither side sees a combinational path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q <= count_d;
      in_ready <= count_d != (AW+1)'(DEPTH);
      out_valid <= count_d != '0;
    end
  end
endmodule
`default_nettype wire

// ---- spb_top.sv ----
// pass-through exchange buffer shared by contactless side and wired host
`timescale 1ns/10ps
`default_nettype none
module spb_top
  import spb_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output var logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var logic [DATA_W-1:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  input wire logic field_present,
  input wire logic vcc_present,
  input wire logic nfc_req_valid,
  output var logic nfc_req_ready,
  input wire logic nfc_req_write,
  input wire logic nfc_req_fast,
  input wire logic [1:0] nfc_req_sector,
  input wire logic [7:0] nfc_req_page,
  input wire logic nfc_authenticated,
  input wire logic nfc_wvalid,
  output logic nfc_wready,
  input wire logic [DATA_W-1:0] nfc_wdata,
  input wire logic nfc_cfg_dir_wr,
  input wire logic nfc_cfg_dir,
  output var logic nfc_rsp_valid,
  output var logic nfc_rsp_ack,
  output var logic nfc_rsp_fwd,
  output var logic [DATA_W-1:0] nfc_rsp_data
);
  // power detect pins come from another domain: two flops each
  logic field_s1_q, field_s2_q, vcc_s1_q, vcc_s2_q;
  always_ff @(posedge aclk)
  begin
    field_s1_q <= field_present;
    field_s2_q <= field_s1_q;
    vcc_s1_q <= vcc_present;
    vcc_s2_q <= vcc_s1_q;
  end
  wire both_pwr = field_s2_q & vcc_s2_q;

  logic pt_q, dir_q, mirror_q, prot_q, auth_en_q, cfg_dir_q, owner_q, boot_q;
  logic [DATA_W-1:0] buf_q [BUF_WORDS];
  spb_nfc_st_t st_q, st_d;
  logic [3:0] idx_q, idx_d, left_q, left_d;

  // ---------------- register bus slave ----------------
  logic [ADDR_W-1:0] waddr_q, raddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire wr_go = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
  wire rd_go = !s_axi_arready & !s_axi_rvalid;
  wire w_sess = waddr_q == REG_SESSION;
  wire w_cfg = waddr_q == REG_CONFIG;
  wire w_stat = waddr_q == REG_STATUS;
  wire w_buf = waddr_q[7:6] == BUF_SEL;
  wire r_sess = raddr_q == REG_SESSION;
  wire r_cfg = raddr_q == REG_CONFIG;
  wire r_stat = raddr_q == REG_STATUS;
  wire r_buf = raddr_q[7:6] == BUF_SEL;
  wire [3:0] w_idx = waddr_q[5:2];
  wire [3:0] r_idx = raddr_q[5:2];
  wire [DATA_W-1:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // host touches the buffer only as owner and in its role
  wire host_wr_ok = pt_q & (owner_q == OWNER_HOST) & (dir_q != DIR_NFC_TO_HOST);
  wire host_rd_ok = pt_q & (owner_q == OWNER_HOST) & (dir_q == DIR_NFC_TO_HOST);
  wire host_buf_wr = wr_go & w_buf & host_wr_ok;
  wire host_buf_rd = rd_go & r_buf & host_rd_ok;
  wire w_err = !(w_sess | w_cfg | w_stat | (w_buf & host_wr_ok));
  wire r_err = !(r_sess | r_cfg | r_stat | (r_buf & host_rd_ok));
  wire sess_wr = wr_go & w_sess & wstrb_q[0];

  // session word reports the live mode bit
  wire [DATA_W-1:0] sess_word = DATA_W'({auth_en_q, prot_q, mirror_q, dir_q, pt_q});
  wire [DATA_W-1:0] stat_word = DATA_W'({pt_q, st_q == ST_FILL, vcc_s2_q, field_s2_q, owner_q});
  wire [DATA_W-1:0] rd_word = r_sess ? sess_word :
                              r_cfg ? DATA_W'(cfg_dir_q) :
                              r_stat ? stat_word :
                              (r_buf & host_rd_ok) ? buf_q[r_idx] : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      waddr_q <= '0;
      raddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (aw_hs)
      begin
        waddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_hs)
      begin
        raddr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= r_err ? RESP_SLVERR : RESP_OKAY;
        s_axi_rdata <= rd_word;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- session and mode control ----------------
  // a request for both modes keeps mirror and drops pass-through
  wire pt_req = wdata_q[SESS_PT] & !wdata_q[SESS_MIRROR];
  wire pt_d = !both_pwr ? 1'b0 : sess_wr ? pt_req : pt_q;
  wire mirror_d = sess_wr ? (wdata_q[SESS_MIRROR] & !pt_d) : (mirror_q & !pt_d);
  // only the host session write or the power-on load moves direction
  wire dir_d = boot_q ? cfg_dir_q : sess_wr ? wdata_q[SESS_DIR] : dir_q;
  wire cfg_host_wr = wr_go & w_cfg & wstrb_q[0];

  // ---------------- contactless side ----------------
  logic [DATA_W-1:0] f_data;
  logic f_valid, f_ready;
  wire nfc_take = nfc_req_valid & nfc_req_ready;
  wire [3:0] p_idx = nfc_req_page[3:0];
  wire sect_main = nfc_req_sector == SECT_MAIN;
  // buffer pages sit at the top of sector 0
  wire in_top = sect_main & (nfc_req_page[7:4] == PAGE_BUF_HI);
  // top sector-0 pages map onto the buffer only while the mode runs
  wire is_buf = in_top & pt_q;
  wire is_sess = (nfc_req_sector == SECT_SESS) & (nfc_req_page == PAGE_SESS0 | nfc_req_page == PAGE_SESS1);
  wire bad_main = sect_main & (nfc_req_page == PAGE_BAD0 | nfc_req_page == PAGE_BAD1 |
                  nfc_req_page == PAGE_BAD2 | nfc_req_page == PAGE_BAD3 | (in_top & !pt_q));
  wire is_fwd = (sect_main & !bad_main & !in_top) | (LARGE_VARIANT & (nfc_req_sector == SECT_EXT));
  // protected buffer needs a completed authentication
  wire prot_block = auth_en_q & prot_q & !nfc_authenticated;
  // contactless side owns the buffer only in its own role
  wire nfc_wr_ok = (owner_q != OWNER_HOST) & (dir_q == DIR_NFC_TO_HOST) & !prot_block;
  wire nfc_rd_ok = (owner_q != OWNER_HOST) & (dir_q != DIR_NFC_TO_HOST) & !prot_block;
  // fast write must start on the first page and covers all sixteen
  wire fast_ok = !nfc_req_fast | (p_idx == PAGE_FIRST);
  wire fill_ok = is_buf & nfc_wr_ok & fast_ok;
  wire [3:0] words_m1 = nfc_req_fast ? 4'hf : 4'h0;
  // filling waits only for a same-cycle host write, never a lock
  wire drain = (st_q == ST_FILL) & f_valid & !host_buf_wr;
  wire drop = (st_q == ST_DISCARD) & f_valid;
  assign f_ready = drain | drop;
  wire fill_last = drain & (left_q == 4'h0);
  wire nfc_rd_buf = nfc_take & !nfc_req_write & is_buf & nfc_rd_ok;

  logic rsp_v_d, rsp_ack_d, rsp_fwd_d;
  logic [DATA_W-1:0] rsp_data_d;
  always_comb
  begin
    st_d = st_q;
    idx_d = idx_q;
    left_d = left_q;
    rsp_v_d = 1'b0;
    rsp_ack_d = 1'b0;
    rsp_fwd_d = 1'b0;
    rsp_data_d = '0;
    if (st_q == ST_IDLE && nfc_take)
    begin
      rsp_v_d = 1'b1;
      if (is_fwd)
        rsp_fwd_d = 1'b1;
      else if (nfc_req_write)
      begin
        // session pages answer ack; their write leaves session bits alone
        rsp_ack_d = is_sess;
        rsp_v_d = !fill_ok;
        idx_d = p_idx;
        left_d = words_m1;
        st_d = fill_ok ? ST_FILL : (is_buf | is_sess) ? ST_DISCARD : ST_IDLE;
      end
      else if (is_sess)
      begin
        rsp_ack_d = 1'b1;
        rsp_data_d = (nfc_req_page == PAGE_SESS0) ? sess_word : stat_word;
      end
      else if (nfc_rd_buf)
      begin
        rsp_ack_d = 1'b1;
        rsp_data_d = buf_q[p_idx];
      end
    end
    else if (drain | drop)
    begin
      idx_d = idx_q + 4'h1;
      left_d = left_q - 4'h1;
      if (left_q == 4'h0)
      begin
        st_d = ST_IDLE;
        rsp_v_d = drain;
        rsp_ack_d = drain;
      end
    end
  end

  // terminator page passes ownership; same rule both ways
  wire to_host = (fill_last & (idx_q == PAGE_TERM)) | (nfc_rd_buf & (p_idx == PAGE_TERM));
  wire to_nfc = (host_buf_wr & (w_idx == PAGE_TERM)) | (host_buf_rd & (r_idx == PAGE_TERM));
  wire owner_d = (pt_d & !pt_q) | (dir_d != dir_q) ? (dir_d != DIR_NFC_TO_HOST) :
                 to_host ? OWNER_HOST : to_nfc ? !OWNER_HOST : owner_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boot_q <= 1'b1;
      pt_q <= 1'b0;
      dir_q <= CONFIG_DIR_RST;
      mirror_q <= 1'b0;
      prot_q <= 1'b0;
      auth_en_q <= 1'b0;
      cfg_dir_q <= CONFIG_DIR_RST;
      owner_q <= !OWNER_HOST;
      st_q <= ST_IDLE;
      idx_q <= '0;
      left_q <= '0;
      nfc_req_ready <= 1'b0;
      nfc_rsp_valid <= 1'b0;
      nfc_rsp_ack <= 1'b0;
      nfc_rsp_fwd <= 1'b0;
      nfc_rsp_data <= '0;
    end
    else
    begin
      boot_q <= 1'b0;
      // enable taken from a host write with both supplies up
      // loss of either supply drops the mode
      pt_q <= pt_d;
      mirror_q <= mirror_d;
      dir_q <= dir_d;
      if (sess_wr)
      begin
        prot_q <= wdata_q[SESS_PROT];
        auth_en_q <= wdata_q[SESS_AUTH_EN];
      end
      // either side may set the power-on default direction
      if (cfg_host_wr)
        cfg_dir_q <= wdata_q[CFG_DIR];
      else if (nfc_cfg_dir_wr)
        cfg_dir_q <= nfc_cfg_dir;
      owner_q <= owner_d;
      st_q <= st_d;
      idx_q <= idx_d;
      left_q <= left_d;
      nfc_req_ready <= st_d == ST_IDLE;
      nfc_rsp_valid <= rsp_v_d;
      nfc_rsp_ack <= rsp_ack_d;
      nfc_rsp_fwd <= rsp_fwd_d;
      nfc_rsp_data <= rsp_data_d;
    end
  end

  // sixteen words of volatile storage, no reset, lost with power
  for (genvar i = 0; i < BUF_WORDS; i++)
  begin : g_word
    always_ff @(posedge aclk)
    begin
      if (drain && idx_q == 4'(i))
        buf_q[i] <= f_data;
      else if (host_buf_wr && w_idx == 4'(i))
        buf_q[i] <= (buf_q[i] & ~wmask) | (wdata_q & wmask);
    end
  end

  // the fifo lets the contactless side stream a fast write without stalls
  spb_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(nfc_wvalid),
    .in_ready(nfc_wready),
    .in_data(nfc_wdata),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence fast_start_s;
    nfc_take && nfc_req_write && nfc_req_fast && fill_ok && st_q == ST_IDLE;
  endsequence
  sequence fast_done_s;
    ##[17:300] (nfc_rsp_valid && nfc_rsp_ack);
  endsequence

  power_drop_a: assert property (!both_pwr |=> !pt_q)
    else $error("pass-through stayed on without power");
  enable_src_a: assert property ($rose(pt_q) |-> $past(sess_wr && both_pwr))
    else $error("pass-through enabled without host write");
  mode_excl_a: assert property (!(pt_q && mirror_q))
    else $error("mirror and pass-through both active");
  dir_owner_a: assert property ($changed(dir_q) |-> $past(sess_wr || boot_q))
    else $error("direction changed without host session write");
  prot_nak_a: assert property (st_q == ST_IDLE && nfc_take && is_buf && prot_block
                               |=> nfc_rsp_valid && !nfc_rsp_ack)
    else $error("protected buffer access not refused");
  sect_nak_a: assert property (st_q == ST_IDLE && nfc_take && nfc_req_sector == SECT_SESS && !is_sess
                               |=> nfc_rsp_valid && !nfc_rsp_ack && !nfc_rsp_fwd)
    else $error("unmapped last-sector page not refused");
  term_hand_a: assert property (fill_last && idx_q == PAGE_TERM && dir_d == dir_q && !(pt_d && !pt_q)
                                |=> owner_q == OWNER_HOST)
    else $error("terminator write did not hand over");
  fast_fill_a: assert property (fast_start_s |-> fast_done_s)
    else $error("fast write did not complete");
  host_reject_a: assert property (wr_go && w_buf && !host_wr_ok && !drain
                                  |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(buf_q[w_idx]))
    else $error("wrong-direction host write not rejected");
  pt_report_a: assert property (rd_go && r_sess |=> s_axi_rdata[SESS_PT] == $past(pt_q))
    else $error("session read does not report mode");
endmodule
`default_nettype wire

// ---- spb_nfc_model.sv ----
// contactless reader model issuing page commands and data words
`timescale 1ns/10ps
`default_nettype none
module spb_nfc_model
  import spb_pkg::*;
(
  input wire logic aclk,
  output var logic req_valid,
  input wire logic req_ready,
  output var logic req_write,
  output var logic req_fast,
  output var logic [1:0] req_sector,
  output var logic [7:0] req_page,
  output var logic wvalid,
  input wire logic wready,
  output var logic [DATA_W-1:0] wdata,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic rsp_fwd,
  input wire logic [DATA_W-1:0] rsp_data
);
  int rsp_cnt = 0;
  logic ack_q = 1'h0;
  logic fwd_q = 1'h0;
  logic [DATA_W-1:0] rd_q = 32'h0;
  initial
  begin
    {req_valid, req_write, req_fast, wvalid} = 4'h0;
    req_sector = 2'h0;
    req_page = 8'h0;
    wdata = 32'h0;
  end
  // the answer is a one-cycle pulse, so it is latched here
  always @(posedge aclk)
    if (rsp_valid === 1'h1)
    begin
      rsp_cnt <= rsp_cnt + 1;
      ack_q <= rsp_ack;
      fwd_q <= rsp_fwd;
      rd_q <= rsp_data;
    end
  // gap inserts idle cycles before each word, a slow reader
  task automatic run(input logic wr, input logic fast, input logic [1:0] sec, input logic [7:0] pg,
    input logic [31:0] base, input int gap, output logic ack, output logic fwd, output logic [31:0] rd);
    int n;
    int c0;
    n = fast ? 16 : int'(wr);
    @(posedge aclk);
    c0 = rsp_cnt;
    req_valid <= 1'h1;
    req_write <= wr;
    req_fast <= fast;
    req_sector <= sec;
    req_page <= pg;
    do @(posedge aclk); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    req_page <= ~pg;
    for (int i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge aclk);
      wvalid <= 1'h1;
      wdata <= base + i;
      do @(posedge aclk); while (wready !== 1'h1);
      // released data lines never keep the last word
      if (gap > 0 || i == n - 1)
      begin
        wvalid <= 1'h0;
        wdata <= ~(base + i);
      end
    end
    while (rsp_cnt == c0) @(posedge aclk);
    ack = ack_q;
    fwd = fwd_q;
    rd = rd_q;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the pass-through exchange buffer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spb_pkg::*;
  localparam logic [7:0] BUF_BASE = 8'h40;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic field_present = 1'h1, vcc_present = 1'h1, nfc_authenticated = 1'h0, nfc_cfg_dir_wr = 1'h0, nfc_cfg_dir = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, nfc_wdata, nfc_rsp_data;
  wire logic nfc_req_valid, nfc_req_ready, nfc_req_write, nfc_req_fast, nfc_wvalid, nfc_wready;
  wire logic nfc_rsp_valid, nfc_rsp_ack, nfc_rsp_fwd;
  wire logic [1:0] nfc_req_sector;
  wire logic [7:0] nfc_req_page;
  logic ack_v, fwd_v;
  logic [31:0] rd_v;
  int bad_count = 0;
  int comparisons = 0;
  spb_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .field_present, .vcc_present,
    .nfc_req_valid, .nfc_req_ready, .nfc_req_write, .nfc_req_fast, .nfc_req_sector, .nfc_req_page,
    .nfc_authenticated, .nfc_wvalid, .nfc_wready, .nfc_wdata, .nfc_cfg_dir_wr, .nfc_cfg_dir,
    .nfc_rsp_valid, .nfc_rsp_ack, .nfc_rsp_fwd, .nfc_rsp_data);
  spb_nfc_model rdr (.aclk, .req_valid(nfc_req_valid), .req_ready(nfc_req_ready), .req_write(nfc_req_write),
    .req_fast(nfc_req_fast), .req_sector(nfc_req_sector), .req_page(nfc_req_page), .wvalid(nfc_wvalid),
    .wready(nfc_wready), .wdata(nfc_wdata), .rsp_valid(nfc_rsp_valid), .rsp_ack(nfc_rsp_ack),
    .rsp_fwd(nfc_rsp_fwd), .rsp_data(nfc_rsp_data));
  always #5 aclk = ~aclk;
  task automatic final_report;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {aw, w} = 2'h3;
    forever
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'h1)
      begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready === 1'h1)
      begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_araddr <= ~a;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk($sformatf("rdata@%h", a), e, s_axi_rdata & m);
    chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic nt(input logic wr, input logic fast, input logic [1:0] sec, input logic [7:0] pg,
    input logic [31:0] base, input int gap, input logic eack);
    rdr.run(wr, fast, sec, pg, base, gap, ack_v, fwd_v, rd_v);
    chk($sformatf("ack %h/%h", sec, pg), {31'h0, eack}, {31'h0, ack_v});
  endtask
  task automatic t_reset;
    axi_rd(REG_SESSION, 32'hffffffff, 32'h0, RESP_OKAY);
    axi_rd(REG_CONFIG, 32'h1, {31'h0, CONFIG_DIR_RST}, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h1e, 32'h6, RESP_OKAY);
    axi_rd(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h1f, RESP_OKAY);
  endtask
  task automatic t_gate;
    vcc_present <= 1'h0;
    repeat (6) @(posedge aclk);
    axi_wr(REG_SESSION, 32'h3, RESP_OKAY);
    axi_rd(REG_SESSION, 32'h1, 32'h0, RESP_OKAY);
    vcc_present <= 1'h1;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_nfc_to_host;
    axi_wr(REG_SESSION, 32'h3, RESP_OKAY);
    axi_rd(REG_SESSION, 32'h1f, 32'h3, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h11, 32'h10, RESP_OKAY);
    axi_wr(BUF_BASE, 32'h1, RESP_SLVERR);
    nt(1'h0, 1'h0, SECT_MAIN, 8'hf0, 32'h0, 0, 1'h0);
    fork
      nt(1'h1, 1'h1, SECT_MAIN, 8'hf0, 32'ha0000000, 2, 1'h1);
      begin
        repeat (8) @(posedge aclk);
        axi_rd(REG_STATUS, 32'h8, 32'h8, RESP_OKAY);
      end
    join
    axi_rd(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
    axi_rd(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
    nt(1'h1, 1'h0, SECT_MAIN, 8'hf0, 32'h77, 0, 1'h0);
    for (int i = 0; i < 16; i++)
      axi_rd(BUF_BASE + 8'(i * 4), 32'hffffffff, 32'ha0000000 + i, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h1, 32'h0, RESP_OKAY);
  endtask
  task automatic t_host_to_nfc;
    axi_wr(REG_SESSION, 32'h1, RESP_OKAY);
    for (int i = 0; i < 16; i++)
      axi_wr(BUF_BASE + 8'(i * 4), 32'h50000000 + i, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h1, 32'h0, RESP_OKAY);
    for (int i = 0; i < 16; i++)
    begin
      nt(1'h0, 1'h0, SECT_MAIN, 8'hf0 + 8'(i), 32'h0, 0, 1'h1);
      chk("nfc page data", 32'h50000000 + i, rd_v);
    end
    axi_rd(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
    nt(1'h1, 1'h0, SECT_SESS, PAGE_SESS0, 32'h2, 0, 1'h1);
    axi_rd(REG_SESSION, 32'h1f, 32'h1, RESP_OKAY);
  endtask
  task automatic t_protect;
    axi_wr(REG_SESSION, 32'h19, RESP_OKAY);
    axi_wr(BUF_BASE + 8'h3c, 32'h5000000f, RESP_OKAY);
    nt(1'h0, 1'h0, SECT_MAIN, 8'hf0, 32'h0, 0, 1'h0);
    nfc_authenticated <= 1'h1;
    nt(1'h0, 1'h0, SECT_MAIN, 8'hf0, 32'h0, 0, 1'h1);
    chk("auth read data", 32'h50000000, rd_v);
    nfc_authenticated <= 1'h0;
  endtask
  task automatic t_pagemap;
    logic [10:0] tbl [11] = '{{SECT_SESS, 8'h00, 1'h0}, {SECT_SESS, 8'hf7, 1'h0}, {SECT_SESS, PAGE_SESS0, 1'h1},
      {SECT_SESS, PAGE_SESS1, 1'h1}, {SECT_SESS, 8'hfa, 1'h0}, {SECT_SESS, 8'hff, 1'h0}, {2'h2, 8'h10, 1'h0},
      {SECT_MAIN, PAGE_BAD0, 1'h0}, {SECT_MAIN, PAGE_BAD1, 1'h0}, {SECT_MAIN, PAGE_BAD2, 1'h0},
      {SECT_MAIN, PAGE_BAD3, 1'h0}};
    foreach (tbl[i])
    begin
      nt(1'h0, 1'h0, tbl[i][10:9], tbl[i][8:1], 32'h0, 0, tbl[i][0]);
      chk("forward flag", 32'h0, {31'h0, fwd_v});
    end
    nt(1'h0, 1'h0, SECT_SESS, PAGE_SESS0, 32'h0, 0, 1'h1);
    chk("session page", 32'h19, rd_v);
    rdr.run(1'h0, 1'h0, SECT_EXT, 8'h10, 32'h0, 0, ack_v, fwd_v, rd_v);
    chk("large forward", 32'h1, {31'h0, fwd_v});
  endtask
  task automatic t_power;
    for (int k = 0; k < 2; k++)
    begin
      axi_wr(REG_SESSION, 32'h1, RESP_OKAY);
      axi_rd(REG_SESSION, 32'h1, 32'h1, RESP_OKAY);
      if (k == 0) field_present <= 1'h0;
      else vcc_present <= 1'h0;
      repeat (8) @(posedge aclk);
      axi_rd(REG_STATUS, 32'h10, 32'h0, RESP_OKAY);
      axi_rd(REG_SESSION, 32'h1, 32'h0, RESP_OKAY);
      {field_present, vcc_present} <= 2'h3;
      repeat (8) @(posedge aclk);
    end
  endtask
  task automatic t_mirror;
    axi_wr(REG_SESSION, 32'h5, RESP_OKAY);
    axi_rd(REG_SESSION, 32'h1f, 32'h4, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h10, 32'h0, RESP_OKAY);
  endtask
  task automatic t_config;
    @(posedge aclk);
    {nfc_cfg_dir_wr, nfc_cfg_dir} <= 2'h3;
    @(posedge aclk);
    {nfc_cfg_dir_wr, nfc_cfg_dir} <= 2'h0;
    axi_rd(REG_CONFIG, 32'h1, 32'h1, RESP_OKAY);
    axi_wr(REG_CONFIG, 32'h0, RESP_OKAY);
    axi_rd(REG_CONFIG, 32'h1, 32'h0, RESP_OKAY);
  endtask
  // fewer than 1000 cycles are needed; the margin covers slow answers
  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_gate();
    t_nfc_to_host();
    t_host_to_nfc();
    t_protect();
    t_pagemap();
    t_power();
    t_mirror();
    t_config();
    final_report();
  end
endmodule
`default_nettype wire
